/* File: include/chan_dma_pkg.sv */
// Shared constants and types for the channel transfer engine.
// Assumes a single 40 MHz clock domain and no software register map.
package chan_dma_pkg;
  localparam int         ADDR_W      = 32;
  localparam int         DATA_W      = 64;
  localparam int         NUM_PAIRS   = 4;
  localparam int         NUM_CHAN    = 8;
  localparam int         PAIR_W      = 2;
  localparam int         CHAN_IDX_W  = 3;
  localparam int         CHAN_NUM_W  = 7;
  localparam int         CHANS_UNIT  = 4;
  localparam int         NUM_UNITS   = 2;
  localparam int         LINK_W      = DATA_W + PAIR_W;
  localparam int         BUF_DEPTH   = 2;
  localparam logic [6:0] CHAN_BASE   = 7'h10;
  localparam logic [6:0] MODULE_STEP = 7'h08;
  localparam logic [31:0] PTR_RST    = 32'h0000_0000;
  localparam logic [31:0] LIM_RST    = 32'h0000_0000;
  localparam logic [31:0] ADDR_ONE   = 32'h0000_0001;

  typedef enum logic [2:0] {
    OP_LOAD_LIMIT = 3'b000,
    OP_LOAD_PTR   = 3'b001,
    OP_CLEAR_INT  = 3'b010,
    OP_READ_PTR   = 3'b011,
    OP_READ_INT   = 3'b100
  } cmd_op_t;
endpackage

/* File: include/word_stream_if.sv */
// Valid/ready word stream between the engine and its buffers.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 66);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: logic/two_entry_buffer.sv */
// Two-entry buffer in a word stream, so a stalled drain loses no word.
// Assumes source and drain sit on clk; async active-high reset.
`timescale 1ns/1ps
module two_entry_buffer (
  input wire logic  clk,             // 40 MHz clock
  input wire logic  rst,             // Async reset, active high
  word_stream_if.snk fillPort,       // Filling side
  word_stream_if.src drainPort       // Draining side
);
  import chan_dma_pkg::*;

  logic [LINK_W-1:0] slot0_r, slot0_nxt;
  logic [LINK_W-1:0] slot1_r, slot1_nxt;
  logic [1:0]        count_r, count_nxt;
  logic              push;
  logic              pop;

  assign fillPort.ready  = (count_r < 2'(BUF_DEPTH));
  assign drainPort.valid = (count_r != 2'h0);
  assign drainPort.data  = slot0_r;
  assign push = fillPort.valid & fillPort.ready;
  assign pop  = drainPort.valid & drainPort.ready;

  always_comb begin
    slot0_nxt = slot0_r;
    slot1_nxt = slot1_r;
    count_nxt = count_r;
    if (pop) begin
      slot0_nxt = slot1_r;
    end
    if (push) begin
      if (count_r == 2'h0 || (count_r == 2'h1 && pop)) begin
        slot0_nxt = fillPort.data;
      end else begin
        slot1_nxt = fillPort.data;
      end
    end
    count_nxt = 2'(count_r + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot0_r <= '0;
      slot1_r <= '0;
      count_r <= 2'h0;
    end else begin
      slot0_r <= slot0_nxt;
      slot1_r <= slot1_nxt;
      count_r <= count_nxt;
    end
  end

  a_buf_no_over: assert property (@(posedge clk) disable iff (rst) count_r <= 2'h2)
    else $error("buffer count beyond two");
  c_buf_full: cover property (@(posedge clk) disable iff (rst) count_r == 2'h2 && !drainPort.ready);
endmodule

/* File: logic/completion_flags.sv */
// Per-channel completion request flags and the interrupting channel index.
// Assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ps
module completion_flags (
  input  wire logic                                clk,     // 40 MHz clock
  input  wire logic                                rst,     // Async reset, active high
  input  wire logic [chan_dma_pkg::NUM_CHAN-1:0]   setVec,  // Transfer finished pulses
  input  wire logic [chan_dma_pkg::NUM_CHAN-1:0]   clrVec,  // Processor clear pulses
  output logic      [chan_dma_pkg::NUM_CHAN-1:0]   flags,   // Pending flags
  output logic                                     anyReq,  // Any flag pending
  output logic      [chan_dma_pkg::CHAN_IDX_W-1:0] firstIdx // Lowest pending index
);
  import chan_dma_pkg::*;

  logic [NUM_CHAN-1:0] flag_r, flag_nxt;

  always_comb begin
    // A finish in the clearing cycle must survive, so set is applied last
    flag_nxt = (flag_r & ~clrVec) | setVec;
    firstIdx = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (flag_r[i]) begin
        firstIdx = CHAN_IDX_W'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flags  = flag_r;
  assign anyReq = |flag_r;

  a_flag_set_wins: assert property (@(posedge clk) disable iff (rst)
      (setVec != '0) |=> ((flag_r & $past(setVec)) == $past(setVec)))
    else $error("completion lost against clear");
endmodule

/* File: logic/io_channel_dma.sv */
// Channel-side transfer engine: four input/output channel pairs on one board.
// Assumes the processor command port, memory port D and link ends share clk.
// What this block does
// - Each channel keeps a loadable next-word pointer
// - Pointer holds first word at start
// - Pointer increments once per moved word
// - Done when pointer equals loadable limit
// - Word at limit address never moves unless a live channel's pointer already equals the limit
// - Four pairs, one input one output
// - Channel data uses dedicated memory port D
// - Two controller units, two pairs each
// - Octal channel numbers per module slot
// - One read plus one write per clock
// - Completion raises an I/O interrupt request
`timescale 1ns/1ps
module io_channel_dma (
  input  wire logic                                 clk,          // 40 MHz clock
  input  wire logic                                 rst,          // Async reset, active high
  input  wire logic [2:0]                           moduleNum,    // Processor module slot, static
  input  wire logic                                 cmdValid,     // Processor command strobe
  input  wire chan_dma_pkg::cmd_op_t                cmdOp,        // Command kind
  input  wire logic [chan_dma_pkg::CHAN_NUM_W-1:0]  cmdChan,      // Octal channel number
  input  wire logic [chan_dma_pkg::ADDR_W-1:0]      cmdData,      // Address operand
  output logic                                      cmdHit,       // Channel belongs to this board
  output logic                                      rspValid,     // Read answer strobe
  output logic      [chan_dma_pkg::ADDR_W-1:0]      rspData,      // Read answer word
  output logic                                      ioIntReq,     // io_interrupt_request level
  output logic      [chan_dma_pkg::CHAN_NUM_W-1:0]  ioIntChan,    // Interrupting channel number
  output logic      [chan_dma_pkg::NUM_UNITS-1:0]   unitBusy,     // Controller unit has a live channel
  output logic                                      rdReq,        // Port D read request
  output logic      [chan_dma_pkg::ADDR_W-1:0]      rdAddr,       // Port D read address
  input  wire logic                                 rdAck,        // Port D read accepted, data valid
  input  wire logic [chan_dma_pkg::DATA_W-1:0]      rdData,       // Port D read data
  output logic                                      wrReq,        // Port D write request
  output logic      [chan_dma_pkg::ADDR_W-1:0]      wrAddr,       // Port D write address
  output logic      [chan_dma_pkg::DATA_W-1:0]      wrData,       // Port D write data
  input  wire logic                                 wrAck,        // Port D write accepted
  output logic                                      linkOutValid, // Word for io_subsystem
  input  wire logic                                 linkOutReady, // io_subsystem takes word
  output logic      [chan_dma_pkg::DATA_W-1:0]      linkOutData,  // Outgoing word
  output logic      [chan_dma_pkg::PAIR_W-1:0]      linkOutPair,  // Pair of outgoing word
  input  wire logic                                 linkInValid,  // Word from io_subsystem
  output logic                                      linkInReady,  // Engine takes word
  input  wire logic [chan_dma_pkg::DATA_W-1:0]      linkInData,   // Incoming word
  input  wire logic [chan_dma_pkg::PAIR_W-1:0]      linkInPair    // Pair of incoming word
);
  import chan_dma_pkg::*;

  // Channel index: pair*2 for input, pair*2+1 for output
  function automatic logic [CHAN_NUM_W:0] chanDecode(input logic [CHAN_NUM_W-1:0] num,
                                                     input logic [2:0]            slot);
    logic [CHAN_NUM_W-1:0] base;
    logic [CHAN_NUM_W-1:0] off;
    base = 7'(CHAN_BASE + 7'(MODULE_STEP * {4'h0, slot}));
    off  = 7'(num - base);
    chanDecode = {(num >= base) && (off < 7'(NUM_CHAN)), off};
  endfunction

  function automatic logic [CHAN_NUM_W-1:0] chanNumber(input logic [CHAN_IDX_W-1:0] idx,
                                                       input logic [2:0]            slot);
    chanNumber = 7'(CHAN_BASE + 7'(MODULE_STEP * {4'h0, slot}) + {4'h0, idx});
  endfunction

  // Round-robin pick of one pair among requesting ones
  function automatic logic [PAIR_W-1:0] pickPair(input logic [NUM_PAIRS-1:0] req,
                                                 input logic [PAIR_W-1:0]    last);
    logic [PAIR_W-1:0] cand;
    pickPair = last;
    for (int k = NUM_PAIRS; k >= 1; k--) begin
      cand = PAIR_W'(last + PAIR_W'(k));
      if (req[cand]) begin
        pickPair = cand;
      end
    end
  endfunction

  logic [ADDR_W-1:0]   ptr_r [NUM_CHAN];
  logic [ADDR_W-1:0]   ptr_nxt [NUM_CHAN];
  logic [ADDR_W-1:0]   lim_r [NUM_CHAN];
  logic [ADDR_W-1:0]   lim_nxt [NUM_CHAN];
  logic [NUM_CHAN-1:0] act_r, act_nxt;
  logic [PAIR_W-1:0]   rdLast_r, rdLast_nxt;
  logic                rspValid_r, rspValid_nxt;
  logic [ADDR_W-1:0]   rspData_r, rspData_nxt;
  logic [NUM_CHAN-1:0] doneVec;
  logic [NUM_CHAN-1:0] clrVec;
  logic [NUM_CHAN-1:0] intFlags;
  logic [CHAN_IDX_W-1:0] intIdx;
  logic [CHAN_NUM_W:0] dec;
  logic [CHAN_IDX_W-1:0] cmdIdx;
  logic [NUM_PAIRS-1:0] outLive;
  logic [PAIR_W-1:0]   rdPair;
  logic [CHAN_IDX_W-1:0] rdIdx;
  logic [CHAN_IDX_W-1:0] wrIdx;
  logic                wrLive;
  logic                rdGo;
  logic                wrGo;

  word_stream_if #(.W(LINK_W)) outFill ();
  word_stream_if #(.W(LINK_W)) outDrain ();
  word_stream_if #(.W(LINK_W)) inFill ();
  word_stream_if #(.W(LINK_W)) inDrain ();

  two_entry_buffer u_out_buf (
    .clk       (clk),
    .rst       (rst),
    .fillPort  (outFill.snk),
    .drainPort (outDrain.src)
  );

  two_entry_buffer u_in_buf (
    .clk       (clk),
    .rst       (rst),
    .fillPort  (inFill.snk),
    .drainPort (inDrain.src)
  );

  completion_flags u_flags (
    .clk      (clk),
    .rst      (rst),
    .setVec   (doneVec),
    .clrVec   (clrVec),
    .flags    (intFlags),
    .anyReq   (ioIntReq),
    .firstIdx (intIdx)
  );

  assign dec    = chanDecode(cmdChan, moduleNum);
  assign cmdHit = cmdValid & dec[CHAN_NUM_W];
  assign cmdIdx = dec[CHAN_IDX_W-1:0];
  assign ioIntChan = chanNumber(intIdx, moduleNum);

  always_comb begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      outLive[p] = act_r[2*p+1];
    end
  end

  // Read side: output channels fetch words from port D
  assign rdPair = pickPair(outLive, rdLast_r);
  assign rdIdx  = CHAN_IDX_W'({rdPair, 1'b1});
  // Only ask when the outgoing buffer can hold the word
  assign rdReq  = (|outLive) & outFill.ready;
  assign rdAddr = ptr_r[rdIdx];
  assign rdGo   = rdReq & rdAck;
  assign outFill.valid = rdGo;
  assign outFill.data  = {rdPair, rdData};

  assign linkOutValid    = outDrain.valid;
  assign outDrain.ready  = linkOutReady;
  assign linkOutData     = outDrain.data[DATA_W-1:0];
  assign linkOutPair     = outDrain.data[LINK_W-1:DATA_W];

  // Write side: input channels store words through port D; runs beside reads
  assign inFill.valid = linkInValid;
  assign inFill.data  = {linkInPair, linkInData};
  assign linkInReady  = inFill.ready;
  assign wrIdx  = CHAN_IDX_W'({inDrain.data[LINK_W-1:DATA_W], 1'b0});
  assign wrLive = act_r[wrIdx];
  assign wrReq  = inDrain.valid & wrLive;
  assign wrAddr = ptr_r[wrIdx];
  assign wrData = inDrain.data[DATA_W-1:0];
  assign wrGo   = wrReq & wrAck;
  // A word for a closed input channel has nowhere to go and is dropped
  assign inDrain.ready = wrAck | ~wrLive;

  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      unitBusy[u] = |act_r[u*CHANS_UNIT +: CHANS_UNIT];
    end
  end

  always_comb begin
    act_nxt      = act_r;
    doneVec      = '0;
    clrVec       = '0;
    rdLast_nxt   = rdGo ? rdPair : rdLast_r;
    rspValid_nxt = 1'b0;
    rspData_nxt  = rspData_r;
    for (int i = 0; i < NUM_CHAN; i++) begin
      ptr_nxt[i] = ptr_r[i];
      lim_nxt[i] = lim_r[i];
      // Advance only on acceptance; stop when the next pointer meets the limit
      if ((rdGo && rdIdx == CHAN_IDX_W'(i)) || (wrGo && wrIdx == CHAN_IDX_W'(i))) begin
        ptr_nxt[i] = ADDR_W'(ptr_r[i] + ADDR_ONE);
        if (ADDR_W'(ptr_r[i] + ADDR_ONE) == lim_r[i]) begin
          act_nxt[i] = 1'b0;
          doneVec[i] = 1'b1;
        end
      end
    end
    if (cmdHit) begin
      unique case (cmdOp)
        OP_LOAD_LIMIT: begin
          lim_nxt[cmdIdx] = cmdData;
        end
        OP_LOAD_PTR: begin
          // Loading starts the channel whatever the limit holds
          ptr_nxt[cmdIdx] = cmdData;
          act_nxt[cmdIdx] = 1'b1;
        end
        OP_CLEAR_INT: begin
          clrVec[cmdIdx] = 1'b1;
        end
        OP_READ_PTR: begin
          rspValid_nxt = 1'b1;
          rspData_nxt  = ptr_r[cmdIdx];
        end
        OP_READ_INT: begin
          rspValid_nxt = 1'b1;
          rspData_nxt  = ADDR_W'(ioIntChan);
        end
        default: begin
          rspValid_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        ptr_r[i] <= PTR_RST;
        lim_r[i] <= LIM_RST;
      end
      act_r      <= '0;
      rdLast_r   <= '0;
      rspValid_r <= 1'b0;
      rspData_r  <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        ptr_r[i] <= ptr_nxt[i];
        lim_r[i] <= lim_nxt[i];
      end
      act_r      <= act_nxt;
      rdLast_r   <= rdLast_nxt;
      rspValid_r <= rspValid_nxt;
      rspData_r  <= rspData_nxt;
    end
  end

  assign rspValid = rspValid_r;
  assign rspData  = rspData_r;

  a_rd_step_one: assert property (@(posedge clk) disable iff (rst)
      rdGo && !(cmdHit && cmdOp == OP_LOAD_PTR && cmdIdx == rdIdx)
      |=> ptr_r[$past(rdIdx)] == $past(rdAddr) + ADDR_ONE)
    else $error("read pointer did not step by one");
  a_wr_step_one: assert property (@(posedge clk) disable iff (rst)
      wrGo && !(cmdHit && cmdOp == OP_LOAD_PTR && cmdIdx == wrIdx)
      |=> ptr_r[$past(wrIdx)] == $past(wrAddr) + ADDR_ONE)
    else $error("write pointer did not step by one");
  a_rd_not_limit: assert property (@(posedge clk) disable iff (rst)
      rdReq |-> act_r[rdIdx])
    else $error("read requested for idle channel");
  a_done_stops: assert property (@(posedge clk) disable iff (rst)
      (doneVec != '0) && !(cmdHit && cmdOp == OP_LOAD_PTR)
      |=> ((act_r & $past(doneVec)) == '0))
    else $error("channel kept going at the limit");
  a_load_starts: assert property (@(posedge clk) disable iff (rst)
      cmdHit && cmdOp == OP_LOAD_PTR |=> act_r[$past(cmdIdx)] && ptr_r[$past(cmdIdx)] == $past(cmdData))
    else $error("pointer load did not start channel");
  a_done_irq: assert property (@(posedge clk) disable iff (rst)
      (doneVec != '0) |=> ioIntReq)
    else $error("completion raised no interrupt");
  // A word taken from port D must be on offer to the link one cycle later
  a_rd_room: assert property (@(posedge clk) disable iff (rst)
      rdGo |=> linkOutValid)
    else $error("fetched word missing from link");
  a_link_hold: assert property (@(posedge clk) disable iff (rst)
      linkOutValid && !linkOutReady |=> linkOutValid && $stable({linkOutPair, linkOutData}))
    else $error("stalled link word changed");
  a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
      act_r == '0 |-> !rdReq && !wrReq)
    else $error("memory request with no live channel");
  a_decode_range: assert property (@(posedge clk) disable iff (rst)
      cmdHit |-> cmdChan >= 7'(CHAN_BASE + 7'(MODULE_STEP * {4'h0, moduleNum})))
    else $error("channel hit below module base");
  a_cmd_answer: assert property (@(posedge clk) disable iff (rst)
      cmdHit && (cmdOp == OP_READ_PTR || cmdOp == OP_READ_INT) |=> rspValid)
    else $error("read command gave no answer");
  a_unit_busy: assert property (@(posedge clk) disable iff (rst)
      unitBusy[1] == |act_r[7:4])
    else $error("unit busy mismatch");
  a_limit_equal: assert property (@(posedge clk) disable iff (rst)
      $fell(act_r[1]) && !$past(rst) |-> ptr_r[1] == lim_r[1])
    else $error("output channel stopped off the limit");

  c_rd_done: cover property (@(posedge clk) disable iff (rst) rdGo ##1 doneVec != '0);
  c_wr_done: cover property (@(posedge clk) disable iff (rst) wrGo && doneVec[wrIdx]);
  c_dual_word: cover property (@(posedge clk) disable iff (rst) rdGo && wrGo);
  c_link_stall: cover property (@(posedge clk) disable iff (rst) linkOutValid && !linkOutReady [*3]);
endmodule

/* File: sim/io_subsystem_model.sv */
// Behavioural io_subsystem at the far end of the link: drains outgoing words with
// stalls, sends a burst of incoming words on request. Assumes the engine's clk and rst.
`timescale 1ns/1ps
module io_subsystem_model (
  input  wire logic        clk,          // 40 MHz clock
  input  wire logic        rst,          // Async reset, active high
  input  wire logic        linkOutValid, // Word offered by engine
  output logic             linkOutReady, // Stalls follow a shift pattern
  output logic             linkInValid,  // Word offered to engine
  input  wire logic        linkInReady,  // Engine takes word
  output logic      [63:0] linkInData,   // Incoming word
  output logic      [1:0]  linkInPair,   // Pair tag of incoming word
  input  wire logic        sendGo,       // Start a burst
  input  wire logic [7:0]  sendCount,    // Words in the burst
  input  wire logic [1:0]  sendPair      // Pair of the burst
);
  logic [7:0]  stallSr;
  logic [7:0]  left;
  logic [31:0] seq;

  // Ready is low for runs of cycles so the engine's buffers fill and refuse
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      stallSr      <= 8'ha5;
      linkOutReady <= 1'b0;
    end else begin
      stallSr      <= {stallSr[6:0], stallSr[7] ^ stallSr[5] ^ stallSr[4] ^ stallSr[3]};
      linkOutReady <= stallSr[0] | stallSr[2];
    end
  end

  // Offer is held until taken; after the last word of a burst the data lines show its inverse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      linkInValid <= 1'b0;
      linkInData  <= 64'h0;
      linkInPair  <= 2'h0;
      left        <= 8'h0;
      seq         <= 32'h0;
    end else if (sendGo && !linkInValid) begin
      linkInValid <= 1'b1;
      linkInData  <= {32'h5a5a_0000, seq};
      linkInPair  <= sendPair;
      left        <= sendCount;
    end else if (linkInValid && linkInReady) begin
      seq  <= seq + 32'h1;
      left <= left - 8'h1;
      if (left == 8'h1) begin
        linkInValid <= 1'b0;
        linkInData  <= ~linkInData;
      end else begin
        linkInData <= {32'h5a5a_0000, seq + 32'h1};
      end
    end
  end
endmodule

/* File: sim/io_channel_address_limit_dma_bench.sv */
// Self-checking bench: command driver, port D memory model and scoreboard queues.
// Assumes chan_dma_pkg, the engine and io_subsystem_model are compiled first.
`timescale 1ns/1ps
module io_channel_address_limit_dma_bench;
  import chan_dma_pkg::*;
  logic        clk, rst, cmdValid, cmdHit, rspValid, ioIntReq, rdReq, rdAck, wrReq, wrAck;
  logic        linkOutValid, linkOutReady, linkInValid, linkInReady, sendGo, dual, inOpen;
  logic [2:0]  moduleNum;
  cmd_op_t     cmdOp;
  logic [6:0]  cmdChan, ioIntChan;
  logic [31:0] cmdData, rspData, rdAddr, wrAddr, expRd, expWr, lfsr = 32'h56e2;
  logic [63:0] rdData, wrData, linkOutData, linkInData;
  logic [1:0]  unitBusy, linkOutPair, linkInPair, curPair, sendPair;
  logic [7:0]  sendCount;
  logic [65:0] outQ[$];
  logic [95:0] wrQ[$];
  logic [31:0] rspQ[$];
  int          n_mismatch, checks_done, nRd, cycles;

  io_channel_dma io_channel_dma_inst (.clk(clk), .rst(rst), .moduleNum(moduleNum), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdChan(cmdChan), .cmdData(cmdData), .cmdHit(cmdHit), .rspValid(rspValid),
    .rspData(rspData), .ioIntReq(ioIntReq), .ioIntChan(ioIntChan), .unitBusy(unitBusy), .rdReq(rdReq),
    .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData), .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData),
    .wrAck(wrAck), .linkOutValid(linkOutValid), .linkOutReady(linkOutReady), .linkOutData(linkOutData),
    .linkOutPair(linkOutPair), .linkInValid(linkInValid), .linkInReady(linkInReady),
    .linkInData(linkInData), .linkInPair(linkInPair));
  io_subsystem_model io_subsystem_model_inst (.clk(clk), .rst(rst), .linkOutValid(linkOutValid),
    .linkOutReady(linkOutReady), .linkInValid(linkInValid), .linkInReady(linkInReady),
    .linkInData(linkInData), .linkInPair(linkInPair), .sendGo(sendGo), .sendCount(sendCount),
    .sendPair(sendPair));

  // Memory answers with a pattern built from the address, so each word is traceable
  assign rdData = {~rdAddr, rdAddr};

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [95:0] seen, input logic [95:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cmd(input cmd_op_t op, input logic [6:0] ch, input logic [31:0] d);
    @(negedge clk);
    cmdValid = 1'b1;
    cmdOp    = op;
    cmdChan  = ch;
    cmdData  = d;
    @(negedge clk);
    cmdValid = 1'b0;
  endtask

  task automatic waitIdle();
    for (int i = 0; i < 600 && (unitBusy !== 2'b00 || outQ.size() != 0 || wrQ.size() != 0); i++)
      @(negedge clk);
    check(unitBusy, 2'b00, "units idle");
    check(outQ.size() + wrQ.size(), 0, "queues drained");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Port D acknowledges come and go at random, read and write independently
  always @(negedge clk) begin
    lfsr  <= lfsrNext(lfsr);
    rdAck <= lfsr[0] | lfsr[3];
    wrAck <= lfsr[5] | lfsr[7];
  end

  // Sampled just before each rising edge, when every combinational output has settled
  always @(negedge clk) begin
    #12;
    if (!rst) begin
      if (rdReq && rdAck) begin
        check(rdAddr, expRd, "read address");
        expRd = expRd + 32'h1;
        nRd++;
        outQ.push_back({curPair, rdData});
        if (wrReq && wrAck)
          dual = 1'b1;
      end
      if (linkOutValid && linkOutReady)
        check({linkOutPair, linkOutData}, outQ.size() ? outQ.pop_front() : 66'hx, "link out");
      if (linkInValid && linkInReady && inOpen) begin
        wrQ.push_back({expWr, linkInData});
        expWr = expWr + 32'h1;
      end
      if (wrReq && wrAck)
        check({wrAddr, wrData}, wrQ.size() ? wrQ.pop_front() : 96'hx, "write word");
      if (rspValid)
        check(rspData, rspQ.size() ? rspQ.pop_front() : 32'hx, "read answer");
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    {cmdValid, sendGo, dual} = 3'b0;
    inOpen    = 1'b1;
    moduleNum = 3'd2;
    cmdOp = OP_CLEAR_INT;
    {cmdChan, cmdData, sendCount, sendPair, curPair} = '0;
    {expRd, expWr, nRd, n_mismatch, checks_done} = '0;
    rst  = 1'b1;
    repeat (4) @(negedge clk);
    check({rdReq, wrReq, linkOutValid, linkInReady, ioIntReq, unitBusy}, 7'b0001000, "reset outputs");
    rst = 1'b0;
    // Every channel number in every module slot: slot s owns octal 20+10*s .. 27+10*s
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 128; c++) begin
        @(negedge clk);
        moduleNum = s[2:0];
        cmdValid  = 1'b1;
        cmdChan   = c[6:0];
        #1 check(cmdHit, (c >= 'o20 + 'o10 * s && c <= 'o27 + 'o10 * s), "channel decode");
      end
    end
    @(negedge clk);
    cmdValid  = 1'b0;
    moduleNum = 3'd2;
    // Output pair 0 and input pair 2 run together, limit loaded first
    cmd(OP_LOAD_LIMIT, 7'o41, 32'h0000_100c);
    expRd = 32'h0000_1000;
    cmd(OP_LOAD_PTR, 7'o41, 32'h0000_1000);
    cmd(OP_LOAD_LIMIT, 7'o44, 32'h0000_2004);
    expWr = 32'h0000_2000;
    cmd(OP_LOAD_PTR, 7'o44, 32'h0000_2000);
    check(unitBusy, 2'b11, "both units live");
    sendCount = 8'h4;
    sendPair  = 2'h2;
    sendGo    = 1'b1;
    @(negedge clk);
    sendGo = 1'b0;
    waitIdle();
    check(nRd, 12, "word at limit not moved");
    check({ioIntReq, dual}, 2'b11, "interrupt and dual traffic");
    rspQ.push_back(32'h0000_100c);
    cmd(OP_READ_PTR, 7'o41, 32'h0);
    rspQ.push_back(32'h0000_2004);
    cmd(OP_READ_PTR, 7'o44, 32'h0);
    rspQ.push_back(32'h0000_0021);
    cmd(OP_READ_INT, 7'o40, 32'h0);
    cmd(OP_CLEAR_INT, 7'o41, 32'h0);
    rspQ.push_back(32'h0000_0024);
    cmd(OP_READ_INT, 7'o40, 32'h0);
    cmd(OP_CLEAR_INT, 7'o44, 32'h0);
    @(negedge clk);
    check({ioIntReq, ioIntChan}, {1'b0, 7'o40}, "flags cleared");
    // A burst for idle input channel 042 is taken off the link and never written
    inOpen    = 1'b0;
    sendCount = 8'h2;
    sendPair  = 2'h1;
    sendGo    = 1'b1;
    @(negedge clk);
    sendGo = 1'b0;
    repeat (20) @(negedge clk);
    check({linkInValid, linkInReady, ioIntReq}, 3'b010, "idle channel word dropped");
    inOpen = 1'b1;
    // Single-word transfer on pair 3 at the top of the address space
    curPair = 2'h3;
    nRd     = 0;
    cmd(OP_LOAD_LIMIT, 7'o47, 32'hffff_fff1);
    expRd = 32'hffff_fff0;
    cmd(OP_LOAD_PTR, 7'o47, 32'hffff_fff0);
    check(unitBusy, 2'b10, "upper unit live");
    waitIdle();
    check({nRd, ioIntReq, ioIntChan}, {32'd1, 1'b1, 7'o47}, "one word then done");
    check(rspQ.size(), 0, "all answers seen");
    tally_and_finish();
  end
endmodule
